// ===== design/vpc_pkg.sv
/*
  constants, types and the gain table shared by the voice port codec.
  assumes a 20 MHz system clock and an 8 kHz voice sample rate.
*/
package vpc_pkg;
  localparam int NPORT = 4;
  localparam int CLK_HZ = 20_000_000;
  localparam int SAMPLE_HZ = 8_000;
  localparam int TICK_CYCLES = CLK_HZ / SAMPLE_HZ;
  localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);
  // level settings are signed counts of 0.5 dB
  localparam logic signed [5:0] LVL_MIN = -6'sd28;
  localparam logic signed [5:0] LVL_MAX = 6'sd8;
  localparam logic signed [5:0] LVL_DEFAULT = 6'sd0;
  localparam logic [6:0] STEP_MAX = 7'h7f;
  localparam logic [6:0] STEP_NOMINAL = 7'h76;
  localparam int FRAC_BITS = 3;
  localparam logic [15:0] STEP_ROUND = 16'h0004;
  localparam logic [11:0] LIN_MAX = 12'h3f8;
  localparam logic [11:0] LIN_NOMINAL = 12'h3b0;
  localparam logic [7:0] ALAW_MASK = 8'h55;
  localparam logic [7:0] MULAW_MASK = 8'h7f;
  localparam logic [7:0] IDLE_RAW = 8'h80;
  localparam logic CAS_ACTIVE = 1'b0;
  localparam logic CAS_IDLE = 1'b1;
  localparam int GAIN_FRAC = 8;
  localparam logic signed [6:0] GAIN_OFS = 7'sd36;
  localparam logic [6:0] GAIN_STEPS_6DB = 7'd12;
  localparam logic [3:0] GAIN_UNITY_OCT = 4'd3;
  // 10^(k/40) in 1/256 units, k = 0..11 half-dB steps within one 6 dB octave
  localparam logic [8:0] GAIN_TBL [12] = '{9'h100, 9'h10f, 9'h11f, 9'h130, 9'h142, 9'h155,
                                          9'h16a, 9'h17f, 9'h196, 9'h1ae, 9'h1c7, 9'h1e2};

  typedef enum logic [1:0] {VPC_LOOP_OFF, VPC_LOOP_LINE, VPC_LOOP_RADIO} vpc_loop_t;
  typedef enum logic {VPC_LAW_A, VPC_LAW_MU} vpc_law_t;

  typedef struct packed {
    logic signed [5:0] in_lvl;
    logic signed [5:0] out_lvl;
    logic e_inv;
    logic m_inv;
    vpc_loop_t loop;
  } vpc_port_cfg_t;

  typedef struct packed {
    logic pcm_on;
    logic sig_en;
  } vpc_xc_t;

  typedef struct packed {
    logic [NPORT-1:0][7:0] code;
    logic [NPORT-1:0] cas;
  } vpc_link_t;
endpackage : vpc_pkg

// ===== design/vpc_codec.sv
/*
  four-port e and m voice codec: level gains, step encoding with a card-wide
  companding mask, cas mapping, loopbacks and a two-entry transmit buffer.
  assumes analogue samples arrive as signed 1/8-step linear values at any
  time (sampled on the internal 8 kHz tick) and a cross-connect with
  valid/ready handshakes on both link directions.
*/
// Contract
// RL1 - e-wire output is active for a received cas 0 and inactive for 1, swapped when inverted.
// RL2 - cas sent is 0 for an active m-wire and 1 for inactive, swapped when inverted.
// RL3 - input and output levels span -14.0 to +4.0 dBr in 0.5 dB steps, default 0 dBr.
// RL4 - the input level scales samples so a nominal input equal to it peaks at code 118.
// RL5 - the output level attenuates decoded samples by the magnitude of a negative setting.
// RL6 - one companding law, a-law by default, applies to all four ports together.
// RL7 - line-facing loopback sends customer traffic to the link and back to the customer.
// RL8 - radio-facing loopback sends link traffic to the customer and back to the link.
// RL9 - each sample is an 8-bit word of steps -127 to +127 with step 0 meaning silence.
// RL10 - a 0 dBm level encodes to peak code 118 and anything above +3.14 dBm0 clips; the code clips at step 127, about +0.64 dBm0.
// RL11 - pcm mode and signalling enable of each port come from the cross-connect.
// RL12 - after gain, magnitudes saturate at 127 instead of wrapping.
`timescale 1ns/100ps
module vpc_codec (
  input wire logic clk,
  input wire logic rst_n,
  input wire vpc_pkg::vpc_law_t law,
  input wire vpc_pkg::vpc_port_cfg_t [3:0] cfg,
  input wire vpc_pkg::vpc_xc_t [3:0] xc,
  input wire logic [3:0][11:0] adc_sample,
  input wire logic [3:0] m_wire,
  output logic [3:0][11:0] dac_sample,
  output logic [3:0] e_wire,
  input wire logic rx_valid,
  input wire vpc_pkg::vpc_link_t rx_word,
  output logic rx_ready,
  output logic tx_valid,
  output vpc_pkg::vpc_link_t tx_word,
  input wire logic tx_ready,
  output logic tx_overrun
);
  import vpc_pkg::*;
  // every check below shares this clock and is quiet while reset is held
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  function automatic logic signed [5:0] lvl_clamp(input logic signed [5:0] lvl);
    if (lvl < LVL_MIN) return LVL_MIN;
    if (lvl > LVL_MAX) return LVL_MAX;
    return lvl;
  endfunction : lvl_clamp

  // gain in half-dB: table covers one 6 dB octave, shifts cover the rest
  function automatic logic [15:0] gain_apply(input logic [11:0] mag,
                                             input logic signed [6:0] hdb);
    logic [6:0] idx;
    logic [3:0] oct;
    logic [3:0] rem;
    logic [23:0] prod;
    idx = 7'(hdb + GAIN_OFS);
    oct = 4'(idx / GAIN_STEPS_6DB);
    rem = 4'(idx % GAIN_STEPS_6DB);
    prod = 24'(mag) * 24'(GAIN_TBL[rem]);
    prod = prod >> GAIN_FRAC;
    if (oct >= GAIN_UNITY_OCT) prod = prod << (oct - GAIN_UNITY_OCT);
    else prod = prod >> (GAIN_UNITY_OCT - oct);
    if (prod > 24'h00ffff) return 16'hffff;
    return prod[15:0];
  endfunction : gain_apply

  function automatic logic [7:0] law_mask(input vpc_law_t l);
    return (l == VPC_LAW_MU) ? MULAW_MASK : ALAW_MASK;
  endfunction : law_mask

  // decode a line code to a linear sample after the output level gain
  function automatic logic [11:0] decode(input logic [7:0] code, input vpc_law_t l,
                                         input logic signed [5:0] out_lvl);
    logic [7:0] raw;
    logic [15:0] lin;
    raw = code ^ law_mask(l);
    lin = gain_apply({2'b00, raw[6:0], 3'b000}, 7'(lvl_clamp(out_lvl))); // see RL5
    if (lin > 16'(LIN_MAX)) lin = 16'(LIN_MAX); // see RL12
    return raw[7] ? lin[11:0] : 12'(-lin[11:0]);
  endfunction : decode

  logic [11:0] tick_cnt;
  logic [11:0] next_tick_cnt;
  logic tick;
  vpc_link_t rx_hold;
  vpc_link_t next_rx_hold;
  vpc_link_t spare;
  vpc_link_t next_spare;
  vpc_link_t next_tx_word;
  vpc_link_t in_word;
  logic spare_valid;
  logic next_spare_valid;
  logic next_tx_valid;
  logic next_rx_ready;
  logic next_tx_overrun;
  logic rx_take;
  logic pop;
  logic push;
  logic in_ready;
  logic [6:0] enc_step [4];
  logic [7:0] enc_code [4];
  logic signed [6:0] in_hdb [4];

  assign tick = (tick_cnt == TICK_LAST);
  assign rx_take = rx_valid && rx_ready;
  assign pop = tx_valid && tx_ready;
  // the spare slot being busy is what stalls new frames
  assign in_ready = !spare_valid;
  assign push = tick && in_ready;

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    logic neg;
    logic [11:0] amag;
    logic [15:0] gained;
    logic [15:0] rounded;
    logic [11:0] next_dac;
    logic next_e;

    assign neg = adc_sample[p][11];
    assign amag = neg ? 12'(-adc_sample[p]) : adc_sample[p];
    assign in_hdb[p] = 7'sd0 - 7'(lvl_clamp(cfg[p].in_lvl)); // see RL3
    assign gained = gain_apply(amag, in_hdb[p]); // see RL4
    assign rounded = (gained + STEP_ROUND) >> FRAC_BITS;
    assign enc_step[p] = (rounded > 16'(STEP_MAX)) ? STEP_MAX : rounded[6:0]; // see RL10
    // zero step always carries the positive sign so silence has one code
    assign enc_code[p] = {!(neg && enc_step[p] != 7'h00), enc_step[p]}
                         ^ law_mask(law); // see RL6, RL9

    assign in_word.code[p] = !xc[p].pcm_on ? (IDLE_RAW ^ law_mask(law)) // see RL11
                           : (cfg[p].loop == VPC_LOOP_RADIO) ? rx_hold.code[p] // see RL8
                           : enc_code[p];
    assign in_word.cas[p] = !xc[p].sig_en ? CAS_IDLE
                          : ((m_wire[p] ? CAS_ACTIVE : CAS_IDLE) ^ cfg[p].m_inv); // see RL2

    always_comb begin
      next_dac = dac_sample[p];
      if (!xc[p].pcm_on) begin
        next_dac = 12'h000; // see RL11
      end else if (cfg[p].loop == VPC_LOOP_LINE) begin
        if (tick) next_dac = decode(enc_code[p], law, cfg[p].out_lvl); // see RL7
      end else if (rx_take) begin
        next_dac = decode(rx_word.code[p], law, cfg[p].out_lvl); // see RL8
      end
      next_e = xc[p].sig_en && ((rx_hold.cas[p] == CAS_ACTIVE) ^ cfg[p].e_inv); // see RL1
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        dac_sample[p] <= 12'h000;
        e_wire[p] <= 1'b0;
      end else begin
        dac_sample[p] <= next_dac;
        e_wire[p] <= next_e;
      end
    end

    property p_e_wire;
      rx_take && xc[p].sig_en && !cfg[p].e_inv && rx_word.cas[p] == CAS_ACTIVE
        ##1 (xc[p].sig_en && !cfg[p].e_inv) |-> ##1 e_wire[p];
    endproperty
    a_e_wire: assert property (p_e_wire) else $error("e-wire not active for cas 0"); // see RL1
    property p_m_wire;
      (xc[p].sig_en && m_wire[p]) |-> in_word.cas[p] == (CAS_ACTIVE ^ cfg[p].m_inv);
    endproperty
    a_m_wire: assert property (p_m_wire) else $error("m-wire cas mapping wrong"); // see RL2
    property p_level_range;
      in_hdb[p] >= -7'(LVL_MAX) && in_hdb[p] <= -7'(LVL_MIN);
    endproperty
    a_level_range: assert property (p_level_range) else $error("level out of range"); // see RL3
    property p_nominal;
      (cfg[p].in_lvl == LVL_DEFAULT && adc_sample[p] == LIN_NOMINAL)
        |-> enc_step[p] == STEP_NOMINAL;
    endproperty
    a_nominal: assert property (p_nominal) else $error("nominal input not at step 118"); // see RL4
    property p_dac_sat;
      $signed(dac_sample[p]) <= $signed({1'b0, LIN_MAX})
        && $signed(dac_sample[p]) >= -$signed({1'b0, LIN_MAX});
    endproperty
    a_dac_sat: assert property (p_dac_sat) else $error("decoded sample past step 127"); // see RL12
    property p_idle_code;
      !xc[p].pcm_on |-> in_word.code[p] == (IDLE_RAW ^ law_mask(law));
    endproperty
    a_idle_code: assert property (p_idle_code) else $error("off port not idle code"); // see RL6
    property p_line_loop;
      (tick && xc[p].pcm_on && cfg[p].loop == VPC_LOOP_LINE)
        ##1 (xc[p].pcm_on && cfg[p].loop == VPC_LOOP_LINE)
        |-> dac_sample[p] == decode($past(enc_code[p]), $past(law), $past(cfg[p].out_lvl));
    endproperty
    a_line_loop: assert property (p_line_loop) else $error("line loopback missing"); // see RL7
    property p_radio_loop;
      (xc[p].pcm_on && cfg[p].loop == VPC_LOOP_RADIO) |-> in_word.code[p] == rx_hold.code[p];
    endproperty
    a_radio_loop: assert property (p_radio_loop) else $error("radio loopback missing"); // see RL8
    property p_pcm_off;
      !xc[p].pcm_on |=> dac_sample[p] == 12'h000;
    endproperty
    a_pcm_off: assert property (p_pcm_off) else $error("off port drives audio"); // see RL11
    property p_clip;
      (cfg[p].in_lvl == LVL_MIN && amag >= 12'h200) |-> enc_step[p] == STEP_MAX;
    endproperty
    a_clip: assert property (p_clip) else $error("overdrive did not clip at 127"); // see RL12
    // silence and idle cas must not depend on the level settings
    property p_e_inv;
      rx_take && xc[p].sig_en && cfg[p].e_inv && rx_word.cas[p] == CAS_IDLE
        ##1 (xc[p].sig_en && cfg[p].e_inv) |-> ##1 e_wire[p];
    endproperty
    a_e_inv: assert property (p_e_inv) else $error("inverted e-wire wrong"); // see RL1
    property p_e_off;
      !xc[p].sig_en |=> !e_wire[p];
    endproperty
    a_e_off: assert property (p_e_off) else $error("e-wire on with signalling off"); // see RL11
    property p_silence;
      adc_sample[p] == 12'h000 |-> enc_code[p] == (IDLE_RAW ^ law_mask(law));
    endproperty
    a_silence: assert property (p_silence) else $error("silence not at step 0"); // see RL9
    property p_rx_silence;
      (rx_take && xc[p].pcm_on && cfg[p].loop != VPC_LOOP_LINE
        && rx_word.code[p] == (IDLE_RAW ^ law_mask(law))) |=> dac_sample[p] == 12'h000;
    endproperty
    a_rx_silence: assert property (p_rx_silence) else $error("silence decoded wrong"); // see RL9
    property p_m_idle;
      (xc[p].sig_en && !m_wire[p]) |-> in_word.cas[p] == (CAS_IDLE ^ cfg[p].m_inv);
    endproperty
    a_m_idle: assert property (p_m_idle) else $error("idle m-wire cas wrong"); // see RL2
    property p_sig_off;
      !xc[p].sig_en |-> in_word.cas[p] == CAS_IDLE;
    endproperty
    a_sig_off: assert property (p_sig_off) else $error("cas not idle when off"); // see RL11
    c_line: cover property (tick && cfg[p].loop == VPC_LOOP_LINE && xc[p].pcm_on);
    c_radio: cover property (tick && cfg[p].loop == VPC_LOOP_RADIO && xc[p].pcm_on);
    c_e_rise: cover property (!e_wire[p] ##1 e_wire[p]);
  end

  // single divider for the 8 kHz frame; a stalled frame is dropped and flagged
  always_comb begin
    next_tick_cnt = tick ? 12'h000 : tick_cnt + 12'h001;
    next_rx_hold = rx_take ? rx_word : rx_hold;
    next_rx_ready = 1'b1;
    next_tx_overrun = tick && !in_ready;
    next_tx_word = tx_word;
    next_tx_valid = tx_valid;
    next_spare = spare;
    next_spare_valid = spare_valid;
    if (!tx_valid || pop) begin
      if (spare_valid) begin
        next_tx_word = spare;
        next_tx_valid = 1'b1;
        next_spare = in_word;
        next_spare_valid = push;
      end else begin
        next_tx_word = in_word;
        next_tx_valid = push;
      end
    end else if (push) begin
      next_spare = in_word;
      next_spare_valid = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt <= 12'h000;
      rx_hold <= '1;
      rx_ready <= 1'b0;
      tx_overrun <= 1'b0;
      tx_word <= '0;
      tx_valid <= 1'b0;
      spare <= '0;
      spare_valid <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      rx_hold <= next_rx_hold;
      rx_ready <= next_rx_ready;
      tx_overrun <= next_tx_overrun;
      tx_word <= next_tx_word;
      tx_valid <= next_tx_valid;
      spare <= next_spare;
      spare_valid <= next_spare_valid;
    end
  end

  property p_tx_hold;
    @(posedge clk) disable iff (!rst_n) tx_valid && !tx_ready |=> tx_valid && $stable(tx_word);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx word lost under stall"); // see RL9
  // the newest frame is the one dropped, so the head word is never torn
  property p_overrun;
    tick && spare_valid |=> tx_overrun;
  endproperty
  a_overrun: assert property (p_overrun) else $error("dropped frame not flagged"); // see RL9
  property p_tx_push;
    tick && !tx_valid && !spare_valid |=> tx_valid && tx_word == $past(in_word);
  endproperty
  a_tx_push: assert property (p_tx_push) else $error("frame not offered after tick"); // see RL9
  property p_rx_ready;
    rst_n |=> rx_ready;
  endproperty
  a_rx_ready: assert property (p_rx_ready) else $error("receive link refused a word"); // see RL8
  c_overrun: cover property (@(posedge clk) disable iff (!rst_n) tx_overrun);
endmodule : vpc_codec

// ===== bench/vpc_xc_model.sv
/* cross-connect sink model for the transmit link.
   assumes the bench drives stall at the falling edge. */
`timescale 1ns/100ps
module vpc_xc_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic tx_valid,
  input wire vpc_pkg::vpc_link_t tx_word,
  output logic tx_ready,
  output vpc_pkg::vpc_link_t last,
  output logic [7:0] n_got
);
  import vpc_pkg::*;
  // ready moves only after an edge, so a stall never splits a handshake
  always_ff @(posedge clk) begin
    tx_ready <= rst_n & ~stall;
    if (!rst_n) n_got <= 8'h00;
    else if (tx_valid && tx_ready) begin
      last <= tx_word;
      n_got <= n_got + 8'h01;
    end
  end
endmodule : vpc_xc_model

// ===== bench/vpc_codec_tb_top.sv
/* self-checking bench for the voice port codec.
   assumes the cross-connect model and a 20 MHz clock. */
`timescale 1ns/100ps
module vpc_codec_tb_top;
  import vpc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  vpc_law_t law = VPC_LAW_A;
  vpc_port_cfg_t [3:0] cfg = '0;
  vpc_xc_t [3:0] xc = '1;
  logic [3:0][11:0] adc = '0;
  logic [3:0] m_wire = '0;
  logic [3:0][11:0] dac;
  logic [3:0] e_wire;
  logic rx_valid = 1'b0;
  vpc_link_t rx_word = '0;
  logic rx_ready, tx_valid, tx_ready, tx_overrun;
  logic stall = 1'b0;
  vpc_link_t tx_word, last, w;
  logic [7:0] n_got;
  int n_errors = 0;
  int samples_checked = 0;
  always #25 clk = ~clk;
  vpc_codec dut (.clk(clk), .rst_n(rst_n), .law(law), .cfg(cfg), .xc(xc),
    .adc_sample(adc), .m_wire(m_wire), .dac_sample(dac), .e_wire(e_wire),
    .rx_valid(rx_valid), .rx_word(rx_word), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_word(tx_word), .tx_ready(tx_ready), .tx_overrun(tx_overrun));
  vpc_xc_model xcm (.clk(clk), .rst_n(rst_n), .stall(stall), .tx_valid(tx_valid),
    .tx_word(tx_word), .tx_ready(tx_ready), .last(last), .n_got(n_got));
  task automatic wrap_up;
    $display("checked %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic chk_v(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk_v
  task automatic tmo;
    n_errors++;
    $display("[ERR] %0t wait ran out", $time);
    wrap_up();
  endtask : tmo
  function automatic logic [7:0] enc(input logic pos, input logic [6:0] st);
    return {pos, st} ^ (law == VPC_LAW_MU ? MULAW_MASK : ALAW_MASK);
  endfunction : enc
  // waits for one accepted frame; callers that change settings take two so the word reflects them
  task automatic frame;
    logic [7:0] n0;
    int i;
    n0 = n_got;
    for (i = 0; i < 6000 && n_got == n0; i++) @(negedge clk);
    if (n_got == n0) tmo();
  endtask : frame
  task automatic send_rx(input vpc_link_t v);
    int i;
    rx_word = v;
    rx_valid = 1'b1;
    for (i = 0; i < 50 && rx_ready !== 1'b1; i++) @(negedge clk);
    if (i == 50) tmo();
    @(negedge clk);
    rx_valid = 1'b0;
    rx_word = ~v;
  endtask : send_rx
  task automatic t_reset;
    repeat (16) @(negedge clk);
    chk_v({rx_ready, tx_valid, e_wire, dac}, '0);
    rst_n = 1'b1;
    @(negedge clk);
    chk_v(rx_ready, 1'b1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_tx(input vpc_law_t l);
    law = l;
    cfg = '0;
    xc = '1;
    adc = {12'h000, 12'h7d0, 12'hc50, 12'h3b0};
    m_wire = 4'b0101;
    cfg[2].m_inv = 1'b1;
    xc[3].sig_en = 1'b0;
    frame();
    frame();
    chk_v(last.cas, 4'b1110);
    chk_v(last.code[0], enc(1'b1, STEP_NOMINAL));
    chk_v(last.code[1], enc(1'b0, STEP_NOMINAL));
    chk_v(last.code[2], enc(1'b1, STEP_MAX));
    chk_v(last.code[3], enc(1'b1, 7'h00));
    $display("test transmit done");
  endtask : t_tx
  task automatic t_gain;
    cfg = '0;
    cfg[0].in_lvl = 6'h34;
    cfg[1].in_lvl = 6'h24;
    cfg[2].in_lvl = 6'h24;
    adc = {12'h000, 12'h200, 12'h064, 12'h1d8};
    frame();
    frame();
    chk_v(last.code[0], enc(1'b1, STEP_NOMINAL));
    chk_v(last.code[1], enc(1'b1, 7'h3f));
    chk_v(last.code[2], enc(1'b1, STEP_MAX));
    $display("test gain done");
  endtask : t_gain
  task automatic t_rx;
    cfg = '0;
    xc = '1;
    cfg[1].e_inv = 1'b1;
    cfg[2].e_inv = 1'b1;
    cfg[1].out_lvl = 6'h34;
    xc[3] = '0;
    w.code = {4{enc(1'b1, STEP_NOMINAL)}};
    w.cas = 4'b0101;
    send_rx(w);
    chk_v(dac, {12'h000, 12'h3b0, 12'h1d8, 12'h3b0});
    @(negedge clk);
    chk_v(e_wire, 4'b0100);
    w.cas = 4'b1010;
    send_rx(w);
    @(negedge clk);
    chk_v(e_wire, 4'b0011);
    $display("test receive done");
  endtask : t_rx
  task automatic t_loop;
    cfg = '0;
    xc = '1;
    cfg[0].loop = VPC_LOOP_LINE;
    cfg[1].loop = VPC_LOOP_RADIO;
    adc = {36'h000000000, 12'h3b0};
    w.code = {enc(1'b1, 7'h00), enc(1'b1, 7'h00), 8'h3c, enc(1'b1, 7'h00)};
    w.cas = 4'hf;
    send_rx(w);
    chk_v(dac[1], 12'hcb8);
    frame();
    frame();
    chk_v(last.code[1], 8'h3c);
    chk_v(last.code[0], enc(1'b1, STEP_NOMINAL));
    chk_v(dac[0], 12'h3b0);
    $display("test loopback done");
  endtask : t_loop
  task automatic t_ovr;
    logic seen;
    logic [7:0] n1;
    seen = 1'b0;
    stall = 1'b1;
    repeat (7700) begin
      @(negedge clk);
      seen = seen | (tx_overrun === 1'b1);
    end
    chk_v({tx_valid, seen}, 2'b11);
    n1 = n_got;
    stall = 1'b0;
    frame();
    @(negedge clk);
    // both buffered words drain back to back once the stall lifts
    chk_v(n_got, 8'(n1 + 8'h02));
    chk_v(last.code[0], enc(1'b1, STEP_NOMINAL));
    $display("test overrun done");
  endtask : t_ovr
  initial begin
    t_reset();
    t_tx(VPC_LAW_A);
    t_tx(VPC_LAW_MU);
    law = VPC_LAW_A;
    t_gain();
    t_rx();
    t_loop();
    t_ovr();
    wrap_up();
  end
endmodule : vpc_codec_tb_top
